/* core/lrbc_pkg.sv */
/*
  lrbc_pkg: constants shared by the logic rail backup control block.
  assumes a 200 MHz system clock and a 4-bit register port.
*/
package lrbc_pkg;
  localparam int LRBC_CLK_HZ = 200000000;
  localparam int LRBC_HOLD_MS = 500;
  // hold time after oscillator start, in cycles of clk
  localparam int LRBC_HOLD_CYC = (LRBC_CLK_HZ / 1000) * LRBC_HOLD_MS;
  localparam int LRBC_DW = 4;
  localparam int LRBC_AW = 4;
  localparam logic [3:0] LRBC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] LRBC_ADDR_STAT = 4'h1;
  localparam logic [3:0] LRBC_ADDR_MASK = 4'h2;
  localparam logic [3:0] LRBC_ADDR_CLKSEL = 4'h3;
  localparam int LRBC_BIT_FLAG = 0;
  localparam int LRBC_BIT_CMPEN = 1;
  localparam int LRBC_BIT_CMPRES = 2;
  localparam logic [3:0] LRBC_CTRL_RST = 4'h0;
  localparam logic [3:0] LRBC_CTRL_WMASK = 4'h3;
  localparam int LRBC_EV_HOLD_END = 0;
  localparam int LRBC_EV_CMP_CHG = 1;
  localparam int LRBC_EV_RAIL_CHG = 2;
  localparam logic [3:0] LRBC_IRQ_RST = 4'h0;
  typedef enum logic [1:0] {
    LRBC_ST_WAIT_OSC,
    LRBC_ST_HOLD,
    LRBC_ST_RUN
  } lrbc_state_e;
endpackage

/* core/lrbc_sync_if.sv */
/*
  lrbc_sync_if: carries the two pin levels from the synchroniser to the top.
  assumes both signals are on clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface lrbc_sync_if;
  logic osc_running;
  logic cmp_above;
  modport src (output osc_running, output cmp_above);
  modport dst (input osc_running, input cmp_above);
endinterface
`default_nettype wire

/* core/lrbc_pin_sync.sv */
/*
  lrbc_pin_sync: three-stage synchroniser for the oscillator-ok and
  comparator pins; a level changes once stages two and three agree.
  assumes pins are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module lrbc_pin_sync
  import lrbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_ok_pin,
  input wire logic cmp_pin,
  lrbc_sync_if.src sync
);
  logic [2:0] osc_sh_reg, osc_sh_next;
  logic [2:0] cmp_sh_reg, cmp_sh_next;
  logic osc_lvl_reg, osc_lvl_next;
  logic cmp_lvl_reg, cmp_lvl_next;

  // shift, then accept a level only when the two late stages agree
  always_comb begin
    osc_sh_next = {osc_sh_reg[1:0], osc_ok_pin};
    cmp_sh_next = {cmp_sh_reg[1:0], cmp_pin};
    osc_lvl_next = osc_lvl_reg;
    cmp_lvl_next = cmp_lvl_reg;
    if (osc_sh_reg[1] == osc_sh_reg[2]) begin
      osc_lvl_next = osc_sh_reg[2];
    end
    if (cmp_sh_reg[1] == cmp_sh_reg[2]) begin
      cmp_lvl_next = cmp_sh_reg[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_sh_reg <= 3'h0;
      cmp_sh_reg <= 3'h0;
      osc_lvl_reg <= 1'b0;
      cmp_lvl_reg <= 1'b0;
    end else begin
      osc_sh_reg <= osc_sh_next;
      cmp_sh_reg <= cmp_sh_next;
      osc_lvl_reg <= osc_lvl_next;
      cmp_lvl_reg <= cmp_lvl_next;
    end
  end

  assign sync.osc_running = osc_lvl_reg;
  assign sync.cmp_above = cmp_lvl_reg;
endmodule
`default_nettype wire

/* core/lrbc_top.sv */
/*
  lrbc_top: logic rail backup control. drives the rail switch that ties
  the logic rail to the negative supply, the comparator enable, and holds
  the backup control register plus an event status/mask pair.
  assumes rst is the system reset, synchronous to clk, and that the
  oscillator-ok and comparator pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
// Operation
// - switch closes on clock select, reset, flag
// - flag set drops rail, clear restores it
// - flag clears on system reset
// - rail forced 0.5 s after oscillator start
// - RC system clock forces rail drop
// - comparator enable bit runs the comparator
// - bit 2 reports comparator result
// - backup control is 4-bit register
module lrbc_top
  import lrbc_pkg::*;
#(
  parameter int HOLD_CYC = LRBC_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [LRBC_AW-1:0] addr,
  input wire logic [LRBC_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [LRBC_DW-1:0] rdata,
  input wire logic osc_ok_pin,
  input wire logic cmp_pin,
  output logic rail_switch,
  output logic comparator_enable,
  output logic system_clock_select,
  output logic irq
);
  lrbc_sync_if sync ();

  lrbc_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .osc_ok_pin(osc_ok_pin),
    .cmp_pin(cmp_pin),
    .sync(sync.src)
  );

  lrbc_state_e state_reg, state_next;
  logic [31:0] hold_cnt_reg, hold_cnt_next;
  logic rail_drop_flag_reg, rail_drop_flag_next;
  logic cmp_en_reg, cmp_en_next;
  logic clk_sel_reg, clk_sel_next;
  logic [LRBC_DW-1:0] status_reg, status_next;
  logic [LRBC_DW-1:0] mask_reg, mask_next;
  logic [LRBC_DW-1:0] rdata_reg, rdata_next;
  logic rail_reg, rail_next;
  logic irq_reg, irq_next;
  logic cmp_last_reg, cmp_last_next;
  logic [LRBC_DW-1:0] events;
  logic cmp_result;

  // register write decode helper
  function automatic logic hit(input logic [LRBC_AW-1:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // comparator result is only meaningful while enabled; hold it at zero otherwise
  assign cmp_result = cmp_en_reg & sync.cmp_above;

  // reset-time hold sequencer: wait for oscillator, then count the hold
  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (state_reg)
      LRBC_ST_WAIT_OSC: begin
        if (sync.osc_running) begin
          state_next = LRBC_ST_HOLD;
          hold_cnt_next = 32'h0;
        end
      end
      LRBC_ST_HOLD: begin
        // counted from the oscillator start regardless of the flag
        if (hold_cnt_reg >= 32'(HOLD_CYC - 1)) begin
          state_next = LRBC_ST_RUN;
        end else begin
          hold_cnt_next = hold_cnt_reg + 32'h1;
        end
      end
      LRBC_ST_RUN: begin
        state_next = LRBC_ST_RUN;
      end
      default: begin
        state_next = LRBC_ST_WAIT_OSC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= LRBC_ST_WAIT_OSC;
      hold_cnt_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // control writes; only flag and enable are writable, result is ignored
  always_comb begin
    rail_drop_flag_next = rail_drop_flag_reg;
    cmp_en_next = cmp_en_reg;
    clk_sel_next = clk_sel_reg;
    mask_next = mask_reg;
    if (wr && hit(addr, LRBC_ADDR_CTRL)) begin
      rail_drop_flag_next = wdata[LRBC_BIT_FLAG];
      cmp_en_next = wdata[LRBC_BIT_CMPEN];
    end
    if (wr && hit(addr, LRBC_ADDR_CLKSEL)) begin
      clk_sel_next = wdata[0];
    end
    if (wr && hit(addr, LRBC_ADDR_MASK)) begin
      mask_next = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rail_drop_flag_reg <= LRBC_CTRL_RST[LRBC_BIT_FLAG];
      cmp_en_reg <= LRBC_CTRL_RST[LRBC_BIT_CMPEN];
      clk_sel_reg <= 1'b0;
      mask_reg <= LRBC_IRQ_RST;
    end else begin
      rail_drop_flag_reg <= rail_drop_flag_next;
      cmp_en_reg <= cmp_en_next;
      clk_sel_reg <= clk_sel_next;
      mask_reg <= mask_next;
    end
  end

  // rail switch: closed during reset (reset value), hold, RC clock, or flag
  always_comb begin
    rail_next = (state_reg != LRBC_ST_RUN) | clk_sel_reg | rail_drop_flag_reg;
  end

  // events: hold finished, comparator changed, rail state changed
  always_comb begin
    events = 4'h0;
    events[LRBC_EV_HOLD_END] = (state_reg == LRBC_ST_HOLD) && (state_next == LRBC_ST_RUN);
    events[LRBC_EV_CMP_CHG] = cmp_result != cmp_last_reg;
    events[LRBC_EV_RAIL_CHG] = rail_next != rail_reg;
    cmp_last_next = cmp_result;
    // set beats a write-one clear in the same cycle
    status_next = status_reg;
    if (wr && hit(addr, LRBC_ADDR_STAT)) begin
      status_next = status_reg & ~wdata;
    end
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rail_reg <= 1'b1;
      status_reg <= LRBC_IRQ_RST;
      cmp_last_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      rail_reg <= rail_next;
      status_reg <= status_next;
      cmp_last_reg <= cmp_last_next;
      irq_reg <= irq_next;
    end
  end

  // read mux; bit 3 of control always reads zero, unmapped reads zero
  always_comb begin
    rdata_next = 4'h0;
    if (rd) begin
      case (addr)
        LRBC_ADDR_CTRL: begin
          rdata_next[LRBC_BIT_FLAG] = rail_drop_flag_reg;
          rdata_next[LRBC_BIT_CMPEN] = cmp_en_reg;
          rdata_next[LRBC_BIT_CMPRES] = cmp_result;
        end
        LRBC_ADDR_STAT: rdata_next = status_reg;
        LRBC_ADDR_MASK: rdata_next = mask_reg;
        LRBC_ADDR_CLKSEL: rdata_next = {3'h0, clk_sel_reg};
        default: rdata_next = 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 4'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign rail_switch = rail_reg;
  assign comparator_enable = cmp_en_reg;
  assign system_clock_select = clk_sel_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

/* sim/lrbc_checker.sv */
/*
  lrbc_checker: port-level assertions for lrbc_top.
  assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module lrbc_checker
  import lrbc_pkg::*;
#(
  parameter int HOLD_CYC = LRBC_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] rdata,
  input wire logic osc_ok_pin,
  input wire logic cmp_pin,
  input wire logic rail_switch,
  input wire logic comparator_enable,
  input wire logic system_clock_select,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // reset is the cause in these two, so they override the default disable
  rail_on_reset_a: assert property (disable iff (1'b0) rst |=> rail_switch)
    else $error("rail open after reset");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !rdata && !irq && !comparator_enable)
    else $error("outputs not cleared by reset");
  clk_sel_rail_a: assert property (system_clock_select [*3] |-> rail_switch)
    else $error("rail open with rc clock");
  flag_drop_a: assert property (wr && addr == LRBC_ADDR_CTRL && wdata[0] |-> ##[1:3] rail_switch)
    else $error("flag set left rail open");
  // a second control write right after would blur which value is expected
  cmp_enable_a: assert property ((wr && addr == LRBC_ADDR_CTRL) ##1 !(wr && addr == LRBC_ADDR_CTRL)
    |=> comparator_enable == $past(wdata[1], 2))
    else $error("comparator enable mismatch");
  read_idle_a: assert property (!rd |=> rdata == 4'h0)
    else $error("read data without read");
  bit3_zero_a: assert property (rd && addr == LRBC_ADDR_CTRL |=> !rdata[3])
    else $error("bit 3 not zero");
  cmp_off_a: assert property (rd && addr == LRBC_ADDR_CTRL && !comparator_enable
    ##1 !comparator_enable |-> rdata[2:1] == 2'b00)
    else $error("result shown while disabled");
  // cycles with the rail forced while the oscillator runs, up to the first drop;
  // the count pauses if the pin falls, so a flaky oscillator stretches the bound
  logic [31:0] osc_hold_cnt;
  logic first_hold;
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_hold_cnt <= 32'h0;
      first_hold <= 1'b1;
    end else begin
      if (rail_switch && osc_ok_pin) begin
        osc_hold_cnt <= osc_hold_cnt + 32'h1;
      end
      if (!rail_switch) begin
        first_hold <= 1'b0;
      end
    end
  end
  hold_span_a: assert property (first_hold && $fell(rail_switch)
    |-> osc_hold_cnt >= 32'(HOLD_CYC))
    else $error("rail released before hold ended");
  // a steady high pin with the comparator running must reach the result bit
  cmp_follow_a: assert property ((comparator_enable && cmp_pin) [*6]
    ##0 (rd && addr == LRBC_ADDR_CTRL) |=> rdata[2])
    else $error("result bit misses comparator");
endmodule
bind lrbc_top lrbc_checker #(.HOLD_CYC(HOLD_CYC)) u_lrbc_checker (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_ok_pin(osc_ok_pin),
  .cmp_pin(cmp_pin), .rail_switch(rail_switch), .comparator_enable(comparator_enable),
  .system_clock_select(system_clock_select), .irq(irq));
`default_nettype wire

/* sim/test_lrbc_top.sv */
/*
  test_lrbc_top: self-checking bench for lrbc_top, random and corner cases.
  assumes the checker binds itself; the hold is shortened to 20 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_lrbc_top
  import lrbc_pkg::*;
;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0, wdata = 4'h0, rdata, d, w;
  logic wr = 1'b0, rd = 1'b0, osc_ok_pin = 1'b0, cmp_pin = 1'b0, s;
  logic rail_switch, comparator_enable, system_clock_select, irq;
  logic [31:0] seed = 32'hf226;
  int mismatches = 0, samples_checked = 0, n;
  always #2.5 clk = ~clk;
  lrbc_top #(.HOLD_CYC(HOLD)) u_lrbc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .osc_ok_pin(osc_ok_pin), .cmp_pin(cmp_pin),
    .rail_switch(rail_switch), .comparator_enable(comparator_enable),
    .system_clock_select(system_clock_select), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // result bit only shows while the comparator runs; bit 3 always zero
  function automatic logic [3:0] ctrl_exp(input logic [3:0] v, input logic c);
    return {1'b0, v[1] & c, v[1], v[0]};
  endfunction
  // the #1 lets the edge's register updates land before anything is sampled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [3:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence: power-up hold, random register traffic, events, reset
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(10);
    `CHK(rail_switch, 1'b1)
    rd_reg(LRBC_ADDR_CTRL);
    `CHK(d, 4'h0)
    osc_ok_pin <= 1'b1;
    for (n = 0; n < 60 && rail_switch !== 1'b0; n++) cyc(1);
    `CHK(n >= HOLD && n <= HOLD + 8, 1'b1)
    rd_reg(LRBC_ADDR_STAT);
    `CHK(d[LRBC_EV_HOLD_END] & ~irq, 1'b1)
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 4'hf : (i == 1) ? 4'h4 : seed[3:0];
      s = seed[4];
      cmp_pin <= seed[5];
      wr_reg(LRBC_ADDR_CLKSEL, {3'h0, s});
      wr_reg(LRBC_ADDR_CTRL, w);
      cyc(6);
      `CHK({rail_switch, system_clock_select}, {s | w[0], s})
      `CHK(comparator_enable, w[1])
      rd_reg(LRBC_ADDR_CTRL);
      `CHK(d, ctrl_exp(w, cmp_pin))
    end
    wr_reg(4'h9, 4'hf);
    rd_reg(4'h9);
    `CHK(d, 4'h0)
    // events: rail change raises irq only while unmasked, w1c clears it
    wr_reg(LRBC_ADDR_CLKSEL, 4'h0);
    wr_reg(LRBC_ADDR_CTRL, 4'h0);
    wr_reg(LRBC_ADDR_STAT, 4'hf);
    wr_reg(LRBC_ADDR_MASK, 4'h4);
    wr_reg(LRBC_ADDR_CTRL, 4'h1);
    cyc(4);
    `CHK(irq, 1'b1)
    wr_reg(LRBC_ADDR_MASK, 4'h0);
    cyc(3);
    `CHK(irq, 1'b0)
    wr_reg(LRBC_ADDR_MASK, 4'h4);
    wr_reg(LRBC_ADDR_STAT, 4'h4);
    cyc(3);
    `CHK(irq, 1'b0)
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    `CHK(rail_switch, 1'b1)
    rd_reg(LRBC_ADDR_CTRL);
    `CHK(d, 4'h0)
    stop_test();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
